// ===== inc/vsr_pkg.sv
package vsr_pkg;

    // Register select codes
    localparam logic [3:0] VSR_RS_PORT_B    = 4'h0;
    localparam logic [3:0] VSR_RS_PORT_A    = 4'h1;
    localparam logic [3:0] VSR_RS_T1_LO     = 4'h4;
    localparam logic [3:0] VSR_RS_T1_HI     = 4'h5;
    localparam logic [3:0] VSR_RS_T2_LO     = 4'h8;
    localparam logic [3:0] VSR_RS_T2_HI     = 4'h9;
    localparam logic [3:0] VSR_RS_SHIFTER   = 4'ha;
    localparam logic [3:0] VSR_RS_AUX       = 4'hb;
    localparam logic [3:0] VSR_RS_FLAGS     = 4'hd;
    localparam logic [3:0] VSR_RS_ENABLES   = 4'he;

    // Flag and enable bit positions
    localparam int VSR_F_CA2  = 0;
    localparam int VSR_F_CA1  = 1;
    localparam int VSR_F_SR   = 2;
    localparam int VSR_F_CB2  = 3;
    localparam int VSR_F_CB1  = 4;
    localparam int VSR_F_T2   = 5;
    localparam int VSR_F_T1   = 6;
    localparam int VSR_F_TOP  = 7;

    // Aux control fields
    localparam int VSR_AUX_DIR = 4;
    localparam int VSR_AUX_LO  = 2;

    // Peripheral control fields
    localparam int VSR_PCR_CA1_POL  = 0;
    localparam int VSR_PCR_CA2_IND  = 1;
    localparam int VSR_PCR_CA2_POL  = 2;
    localparam int VSR_PCR_CA2_OUT  = 3;
    localparam int VSR_PCR_CB1_POL  = 4;
    localparam int VSR_PCR_CB2_LVL  = 5;
    localparam int VSR_PCR_CB2_POL  = 6;
    localparam int VSR_PCR_CB2_OUT  = 7;

    // Shifter modes
    localparam logic [2:0] VSR_MODE_OFF      = 3'h0;
    localparam logic [2:0] VSR_MODE_IN_T2    = 3'h1;
    localparam logic [2:0] VSR_MODE_IN_SYS   = 3'h2;
    localparam logic [2:0] VSR_MODE_IN_EXT   = 3'h3;
    localparam logic [2:0] VSR_MODE_OUT_FREE = 3'h4;
    localparam logic [2:0] VSR_MODE_OUT_T2   = 3'h5;
    localparam logic [2:0] VSR_MODE_OUT_SYS  = 3'h6;
    localparam logic [2:0] VSR_MODE_OUT_EXT  = 3'h7;

    // Modulo-8 bit counter
    localparam logic [2:0] VSR_CNT_ZERO = 3'h0;
    localparam logic [2:0] VSR_CNT_ONE  = 3'h1;
    localparam logic [2:0] VSR_CNT_LAST = 3'h7;
    localparam logic [7:0] VSR_RATE_ONE = 8'h01;

    // Pin sampler slots
    localparam int VSR_NUM_SYNC = 5;
    localparam int VSR_S_CA2  = 0;
    localparam int VSR_S_CA1  = 1;
    localparam int VSR_S_CB2  = 2;
    localparam int VSR_S_CB1  = 3;
    localparam int VSR_S_TOG  = 4;

    typedef struct packed {
        logic [7:0] serial_shifter;
        logic [7:0] aux_control_reg;
        logic [6:0] interrupt_flags;
        logic [6:0] interrupt_enables;
        logic [2:0] bit_cnt;
        logic       active;
        logic       sclk;
        logic [7:0] rate_cnt;
        logic [7:0] rdata;
        logic [3:0] pin_prev;
        logic       ext_tog_prev;
    } vsr_state_t;

    localparam vsr_state_t VSR_STATE_RST = '{
        serial_shifter:    8'h00,
        aux_control_reg:   8'h00,
        interrupt_flags:   7'h00,
        interrupt_enables: 7'h00,
        bit_cnt:           3'h0,
        active:            1'b0,
        sclk:              1'b1,
        rate_cnt:          8'h00,
        rdata:             8'h00,
        pin_prev:          4'h0,
        ext_tog_prev:      1'b0
    };

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
    } vsr_sync_t;

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
        logic tog;
    } vsr_link_t;

endpackage

// ===== rtl/vsr_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module vsr_sync3
    import vsr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      level_o
);
    import vsr_pkg::*;

    vsr_sync_t q;
    vsr_sync_t d;

    // Three stages, level moves only when stages two and three agree
    always_comb begin
        d       = q;
        d.ff1   = async_i;
        d.ff2   = q.ff1;
        d.ff3   = q.ff2;
        if (q.ff2 == q.ff3) begin
            d.level = q.ff3;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{ff1: async_i, ff2: async_i, ff3: async_i, level: async_i}; // No false edge after reset
        end else begin
            q <= d;
        end
    end

    assign level_o = q.level;
endmodule
`default_nettype wire

// ===== rtl/vsr_link_tog.sv
`timescale 1ns/100ps
`default_nettype none
module vsr_link_tog
    import vsr_pkg::*;
(
    input  wire logic lnk_clk_i,
    input  wire logic lnk_rst_i,
    input  wire logic pin_i,
    output logic      tog_o
);
    import vsr_pkg::*;

    vsr_link_t q;
    vsr_link_t d;

    // Pin passes three stages; a settled rise flips the toggle once
    always_comb begin
        d     = q;
        d.ff1 = pin_i;
        d.ff2 = q.ff1;
        d.ff3 = q.ff2;
        if (q.ff2 == q.ff3) begin
            d.level = q.ff3;
            if (q.ff3 && !q.level) begin
                d.tog = ~q.tog;
            end
        end
    end

    always_ff @(posedge lnk_clk_i) begin
        if (lnk_rst_i) begin
            q <= '{ff1: pin_i, ff2: pin_i, ff3: pin_i, level: pin_i, tog: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign tog_o = q.tog;
endmodule
`default_nettype wire

// ===== rtl/vsr_top.sv
// How it works
// - Shifter moves bits on the data pin; modulo-8 counter tracks shift pulses.
// - Aux bit 4 picks input or output; bits 3 and 2 pick clock source.
// - Mode 000 stops shifting, access still works, shifter flag held zero.
// - Mode 001 shifts in at timer 2 low latch rate, flag after 8.
// - Modes 001 and 010 start on shifter access; bits enter bit 0 on trailing edge.
// - Mode 010 shifts in at system rate, pulses stop after 8, flag set.
// - Mode 011 external clock, flag every 8 bits, access clears and restarts count.
// - External clock shifts several cycles after pin rises, once the link toggle passes its sampler; source holds data stable.
// - Output modes drive msb onto data pin and rotate msb into bit 0.
// - Mode 100 shifts out forever at timer 2 rate, counter runs but never sets the flag.
// - Mode 101 sends 8 bits per access, then stops, flags, pin idles at control level.
// - Mode 101 reload before last timeout continues without pause.
// - Mode 110 shifts out at system clock rate, timer 2 untouched.
// - Mode 111 shifts out on external pulses, flag every 8, access restarts count.
// - Request line pulled low whenever a flag and its enable are both set.
// - Flag register bit 7 reads the OR of enabled flags; writes ignored.
// - Shifter flag set after eight shifts except in mode 100, cleared by any shifter access.
// - Port A edge flags set on active edges (CA2 only while control bit 3 clear), cleared by port A access (CA2 only while control bit 1 clear).
// - Port B edge flags set on active edges (CB2 only while mode is 000 and control bit 7 clear), cleared by port B access (CB2 only while control bit 5 clear).
// - Timer flags set on timeouts, cleared by low read or high write.
// - Enable write: bit 7 picks set or clear for ones; reads give bit 7 zero.
// - Writing one to a flag bit clears that flag.
`timescale 1ns/100ps
`default_nettype none
module vsr_top
    import vsr_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       cs_i,
    input  wire logic       rw_i,
    input  wire logic [3:0] rs_i,
    input  wire logic [7:0] wdata_i,
    output logic [7:0]      rdata_o,
    input  wire logic [7:0] peripheral_ctrl_reg_i,
    input  wire logic [7:0] t2_latch_lo_i,
    input  wire logic       t1_timeout_i,
    input  wire logic       t2_timeout_i,
    input  wire logic       port_a_edge_in_one_i,
    input  wire logic       port_a_ctrl_line_two_i,
    input  wire logic       shift_clk_link_i,
    input  wire logic       shift_clock_pin_i,
    output logic            shift_clock_pin_o,
    output logic            shift_clock_pin_oe_n_o,
    input  wire logic       shift_data_pin_i,
    output logic            shift_data_pin_o,
    output logic            shift_data_pin_oe_n_o,
    input  wire logic       irq_n_i,
    output logic            irq_n_o,
    output logic            irq_n_oe_n_o
);
    import vsr_pkg::*;

    vsr_state_t q;
    vsr_state_t d;

    logic                    lnk_tog;
    logic [VSR_NUM_SYNC-1:0] sync_in;
    logic [VSR_NUM_SYNC-1:0] sync_lvl;
    logic [2:0]              mode;
    logic                    dir_out;
    logic                    mode_ext;
    logic                    mode_int;
    logic                    rd;
    logic                    wr;
    logic                    sh_acc;
    logic                    ora_acc;
    logic                    orb_acc;
    logic                    ext_rise;
    logic                    shift_now;
    logic                    set_sr;
    logic                    irq_any;
    logic                    in_bit;
    logic [6:0]              edge_hit;
    logic [6:0]              flag_set;
    logic [6:0]              flag_clr;
    logic [3:0]              pin_now;
    logic [7:0]              rd_val;

    // Link domain: counts rising edges of the shift clock pin
    vsr_link_tog u_link (
        .lnk_clk_i (shift_clk_link_i),
        .lnk_rst_i (sys_rst_i),
        .pin_i     (shift_clock_pin_i),
        .tog_o     (lnk_tog)
    );

    // Pin and link samplers
    assign sync_in = {lnk_tog, shift_clock_pin_i, shift_data_pin_i,
                      port_a_edge_in_one_i, port_a_ctrl_line_two_i};

    genvar gi;
    generate
        for (gi = 0; gi < VSR_NUM_SYNC; gi++) begin : g_sync
            vsr_sync3 u_sync (
                .clk_i   (ref_clk_i),
                .rst_i   (sys_rst_i),
                .async_i (sync_in[gi]),
                .level_o (sync_lvl[gi])
            );
        end
    endgenerate

    // Mode decode and bus access decode
    assign mode     = q.aux_control_reg[VSR_AUX_DIR:VSR_AUX_LO];
    assign dir_out  = q.aux_control_reg[VSR_AUX_DIR];
    assign mode_ext = (mode == VSR_MODE_IN_EXT) || (mode == VSR_MODE_OUT_EXT);
    assign mode_int = (mode != VSR_MODE_OFF) && !mode_ext;
    assign rd       = cs_i && rw_i;
    assign wr       = cs_i && !rw_i;
    assign sh_acc   = cs_i && (rs_i == VSR_RS_SHIFTER);
    assign ora_acc  = cs_i && (rs_i == VSR_RS_PORT_A);
    assign orb_acc  = cs_i && (rs_i == VSR_RS_PORT_B);
    assign ext_rise = sync_lvl[VSR_S_TOG] != q.ext_tog_prev;
    assign irq_any  = |(q.interrupt_flags & q.interrupt_enables);
    assign in_bit   = sync_lvl[VSR_S_CB2];
    assign pin_now  = sync_lvl[VSR_S_CB1:VSR_S_CA2];

    // Active transition detect per pin, polarity from peripheral control
    always_comb begin
        edge_hit = '0;
        edge_hit[VSR_F_CA2] = peripheral_ctrl_reg_i[VSR_PCR_CA2_POL]
                              ? (pin_now[VSR_S_CA2] && !q.pin_prev[VSR_S_CA2])
                              : (!pin_now[VSR_S_CA2] && q.pin_prev[VSR_S_CA2]);
        edge_hit[VSR_F_CA1] = peripheral_ctrl_reg_i[VSR_PCR_CA1_POL]
                              ? (pin_now[VSR_S_CA1] && !q.pin_prev[VSR_S_CA1])
                              : (!pin_now[VSR_S_CA1] && q.pin_prev[VSR_S_CA1]);
        edge_hit[VSR_F_CB2] = peripheral_ctrl_reg_i[VSR_PCR_CB2_POL]
                              ? (pin_now[VSR_S_CB2] && !q.pin_prev[VSR_S_CB2])
                              : (!pin_now[VSR_S_CB2] && q.pin_prev[VSR_S_CB2]);
        edge_hit[VSR_F_CB1] = peripheral_ctrl_reg_i[VSR_PCR_CB1_POL]
                              ? (pin_now[VSR_S_CB1] && !q.pin_prev[VSR_S_CB1])
                              : (!pin_now[VSR_S_CB1] && q.pin_prev[VSR_S_CB1]);
    end

    // Read data selection
    always_comb begin
        case (rs_i)
            VSR_RS_SHIFTER: rd_val = q.serial_shifter;
            VSR_RS_AUX:     rd_val = q.aux_control_reg;
            VSR_RS_FLAGS:   rd_val = {irq_any, q.interrupt_flags};
            VSR_RS_ENABLES: rd_val = {1'b0, q.interrupt_enables};
            default:        rd_val = 8'h00;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        d         = q;
        shift_now = 1'b0;
        set_sr    = 1'b0;
        flag_set  = '0;
        flag_clr  = '0;

        d.pin_prev     = pin_now;
        d.ext_tog_prev = sync_lvl[VSR_S_TOG];

        // Shift pulse generation per clock source
        case (mode)
            VSR_MODE_OFF: begin
                d.active = 1'b0;
                d.sclk   = 1'b1;
            end
            VSR_MODE_IN_T2, VSR_MODE_OUT_T2, VSR_MODE_OUT_FREE: begin
                if (q.active) begin
                    if (q.rate_cnt == '0) begin
                        d.rate_cnt = t2_latch_lo_i;
                        d.sclk     = ~q.sclk;
                        shift_now  = !q.sclk;
                    end else begin
                        d.rate_cnt = q.rate_cnt - VSR_RATE_ONE;
                    end
                end
            end
            VSR_MODE_IN_SYS, VSR_MODE_OUT_SYS: begin
                if (q.active) begin
                    d.sclk    = ~q.sclk;
                    shift_now = !q.sclk;
                end
            end
            VSR_MODE_IN_EXT, VSR_MODE_OUT_EXT: begin
                d.active  = 1'b0;
                d.sclk    = 1'b1;
                shift_now = ext_rise;
            end
            default: begin
                d.active = 1'b0;
            end
        endcase

        // Shift step: rotate msb in output modes, pin bit in input modes
        if (shift_now) begin
            if (dir_out) begin
                d.serial_shifter = {q.serial_shifter[6:0], q.serial_shifter[7]};
            end else begin
                d.serial_shifter = {q.serial_shifter[6:0], in_bit};
            end
            d.bit_cnt = q.bit_cnt + VSR_CNT_ONE;
            if ((q.bit_cnt == VSR_CNT_LAST) && (mode != VSR_MODE_OUT_FREE)) begin
                set_sr = 1'b1;
                if (mode_int) begin
                    d.active = 1'b0;
                    d.sclk   = 1'b1;
                end
            end
        end

        // Shifter access starts or restarts a byte
        if (sh_acc) begin
            d.bit_cnt = VSR_CNT_ZERO;
            if (mode_int) begin
                d.active = 1'b1;
                if (!q.active) begin
                    d.rate_cnt = t2_latch_lo_i;
                    d.sclk     = 1'b1;
                end
            end
            if (wr) begin
                d.serial_shifter = wdata_i;
            end
        end

        // Aux control write
        if (wr && (rs_i == VSR_RS_AUX)) begin
            d.aux_control_reg = wdata_i;
        end

        // Enable register set or clear
        if (wr && (rs_i == VSR_RS_ENABLES)) begin
            if (wdata_i[VSR_F_TOP]) begin
                d.interrupt_enables = q.interrupt_enables | wdata_i[6:0];
            end else begin
                d.interrupt_enables = q.interrupt_enables & ~wdata_i[6:0];
            end
        end

        // Flag sources
        flag_set[VSR_F_CA2] = edge_hit[VSR_F_CA2] && !peripheral_ctrl_reg_i[VSR_PCR_CA2_OUT];
        flag_set[VSR_F_CA1] = edge_hit[VSR_F_CA1];
        flag_set[VSR_F_SR]  = set_sr;
        flag_set[VSR_F_CB2] = edge_hit[VSR_F_CB2] && (mode == VSR_MODE_OFF)
                              && !peripheral_ctrl_reg_i[VSR_PCR_CB2_OUT];
        flag_set[VSR_F_CB1] = edge_hit[VSR_F_CB1];
        flag_set[VSR_F_T2]  = t2_timeout_i;
        flag_set[VSR_F_T1]  = t1_timeout_i;

        // Flag clear sources
        flag_clr[VSR_F_CA2] = ora_acc && !peripheral_ctrl_reg_i[VSR_PCR_CA2_IND];
        flag_clr[VSR_F_CA1] = ora_acc;
        flag_clr[VSR_F_SR]  = sh_acc;
        flag_clr[VSR_F_CB2] = orb_acc && !peripheral_ctrl_reg_i[VSR_PCR_CB2_LVL];
        flag_clr[VSR_F_CB1] = orb_acc;
        flag_clr[VSR_F_T2]  = (rd && (rs_i == VSR_RS_T2_LO)) || (wr && (rs_i == VSR_RS_T2_HI));
        flag_clr[VSR_F_T1]  = (rd && (rs_i == VSR_RS_T1_LO)) || (wr && (rs_i == VSR_RS_T1_HI));
        if (wr && (rs_i == VSR_RS_FLAGS)) begin
            flag_clr = flag_clr | wdata_i[6:0];
        end

        // Set wins over clear
        d.interrupt_flags = (q.interrupt_flags & ~flag_clr) | flag_set;
        if (mode == VSR_MODE_OFF) begin
            d.interrupt_flags[VSR_F_SR] = 1'b0;
        end

        // Registered read data
        if (rd) begin
            d.rdata = rd_val;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            q              <= VSR_STATE_RST;
            q.pin_prev     <= pin_now;                                        // No false edge after reset
            q.ext_tog_prev <= sync_lvl[VSR_S_TOG];
        end else begin
            q <= d;
        end
    end

    // Pin drive: clock pin out in internal modes, data pin out in output modes
    assign rdata_o                = q.rdata;
    assign shift_clock_pin_o      = q.sclk;
    assign shift_clock_pin_oe_n_o = !mode_int;
    assign shift_data_pin_o       = ((mode == VSR_MODE_OUT_T2) && !q.active)
                                    ? peripheral_ctrl_reg_i[VSR_PCR_CB2_LVL]
                                    : q.serial_shifter[7];
    assign shift_data_pin_oe_n_o  = !dir_out;
    assign irq_n_o                = 1'b0;
    assign irq_n_oe_n_o           = !irq_any;

    // Checks
    AST_IRQ_LEVEL: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (|(q.interrupt_flags & q.interrupt_enables)) |-> (!irq_n_oe_n_o && !irq_n_o))
        else $error("request line not pulled low with enabled flag");

    AST_FLAG_TOP_READ: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (rd && (rs_i == VSR_RS_FLAGS))
        |=> (rdata_o[7] == $past(|(q.interrupt_flags & q.interrupt_enables))))
        else $error("flag register bit 7 wrong on read");

    AST_ENABLE_TOP_READ: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (rd && (rs_i == VSR_RS_ENABLES)) |=> (rdata_o[7] == 1'b0))
        else $error("enable register bit 7 not zero on read");

    AST_ENABLE_SET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr && (rs_i == VSR_RS_ENABLES) && wdata_i[7])
        |=> ((q.interrupt_enables & $past(wdata_i[6:0])) == $past(wdata_i[6:0])))
        else $error("enable set write lost bits");

    AST_SR_FLAG_OFF: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ((mode == VSR_MODE_OFF) && !(wr && (rs_i == VSR_RS_AUX)))
        |=> !q.interrupt_flags[VSR_F_SR])
        else $error("shifter flag set while shifter disabled");

    AST_SR_FLAG_CLR: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (sh_acc && !set_sr) |=> !q.interrupt_flags[VSR_F_SR])
        else $error("shifter access did not clear shifter flag");

    AST_SYS_BYTE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ((sh_acc && (mode == VSR_MODE_IN_SYS) && !q.active)
         ##1 (!cs_i)[*8] ##1 (!cs_i)[*8])
        |=> (!q.active && q.interrupt_flags[VSR_F_SR] && shift_clock_pin_o))
        else $error("system rate byte not done in 16 cycles");

    AST_ROTATE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (shift_now && dir_out && !(wr && sh_acc))
        |=> (q.serial_shifter[0] == $past(q.serial_shifter[7])))
        else $error("output shift did not rotate msb into bit 0");

    AST_FLAG_WCLR: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (wr && (rs_i == VSR_RS_FLAGS) && wdata_i[VSR_F_T1] && !t1_timeout_i)
        |=> !q.interrupt_flags[VSR_F_T1])
        else $error("write one did not clear timer 1 flag");
endmodule
`default_nettype wire

// ===== verification/vsr_ext_dev.sv
`timescale 1ns/100ps
`default_nettype none
module vsr_ext_dev (
    input  wire logic clk_pin_i,
    input  wire logic dat_pin_i,
    input  wire logic ext_i,
    output logic      clk_drv_o,
    output logic      dat_drv_o
);
    logic [7:0] tx_q = 8'h00;
    logic [7:0] rx_q = 8'h00;
    int         nbits = 0;

    initial clk_drv_o = 1'b1;
    initial dat_drv_o = 1'b0;
    // Take a bit while the block's clock is low
    always @(negedge clk_pin_i) begin
        if (!ext_i) begin
            #1;
            rx_q = {rx_q[6:0], dat_pin_i};
            nbits++;
        end
    end
    // Next bit late in the low phase, stable well past capture
    always @(posedge clk_pin_i) begin
        #700;
        tx_q = {tx_q[6:0], tx_q[7]};
        dat_drv_o = tx_q[7];
    end
    // Put a byte up, first bit on the line at once
    task load(input logic [7:0] b);
        tx_q = b;
        dat_drv_o = b[7];
    endtask
    // Eight pulses of eight cycles, clock idles high
    task frame();
        repeat (8) begin
            clk_drv_o = 1'b0;
            #400;
            rx_q = {rx_q[6:0], dat_pin_i};
            clk_drv_o = 1'b1;
            #400;
        end
    endtask
endmodule
`default_nettype wire

// ===== verification/serial_shifter_with_irq_logic_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_shifter_with_irq_logic_tb;
    import vsr_pkg::*;
    logic       clk = 1'b0;
    logic       lnk = 1'b0;
    logic       rst = 1'b1;
    logic       cs = 1'b0;
    logic       rw = 1'b1;
    logic [3:0] rs = 4'h0;
    logic [7:0] wd = 8'h00;
    logic [7:0] peripheral_ctrl_reg = 8'h00;
    logic [7:0] lat = 8'h00;
    logic       t1 = 1'b0;
    logic       t2 = 1'b0;
    logic       pa = 1'b1;
    logic       ext = 1'b0;
    logic       din = 1'b0;
    logic       c_last = 1'b1;
    logic       d_last = 1'b0;
    logic [7:0] rdata, r, b;
    logic       c_o, c_oe_n, d_o, d_oe_n, irq_oe_n, p_c, p_d;
    wire logic  clk_w = !c_oe_n ? c_o : (ext ? p_c : ~c_last);
    wire logic  dat_w = !d_oe_n ? d_o : (din ? p_d : ~d_last);
    int         errors = 0;
    int         compares = 0;
    int         seed = 44259;
    int         k;

    vsr_top i_dut (
        .ref_clk_i(clk), .sys_rst_i(rst), .cs_i(cs), .rw_i(rw), .rs_i(rs), .wdata_i(wd), .rdata_o(rdata),
        .peripheral_ctrl_reg_i(peripheral_ctrl_reg), .t2_latch_lo_i(lat), .t1_timeout_i(t1), .t2_timeout_i(t2),
        .port_a_edge_in_one_i(pa), .port_a_ctrl_line_two_i(pa), .shift_clk_link_i(lnk),
        .shift_clock_pin_i(clk_w), .shift_clock_pin_o(c_o), .shift_clock_pin_oe_n_o(c_oe_n),
        .shift_data_pin_i(dat_w), .shift_data_pin_o(d_o), .shift_data_pin_oe_n_o(d_oe_n),
        .irq_n_i(irq_oe_n), .irq_n_o(), .irq_n_oe_n_o(irq_oe_n)
    );
    vsr_ext_dev i_dev (.clk_pin_i(clk_w), .dat_pin_i(dat_w), .ext_i(ext), .clk_drv_o(p_c), .dat_drv_o(p_d));

    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One register access; read data lands in r
    task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        cs <= 1'b1;
        rw <= !w;
        rs <= a;
        wd <= d;
        @(posedge clk);
        cs <= 1'b0;
        @(posedge clk);
        #1 r = rdata;
    endtask
    task wait_flag();
        r = 8'h00;
        for (k = 0; k < 400 && !r[VSR_F_SR]; k++) acc(0, VSR_RS_FLAGS, 8'h00);
    endtask
    task wait_bits(input int n);
        k = i_dev.nbits + n;
        for (int j = 0; j < 4000 && i_dev.nbits < k; j++) #100;
    endtask
    task finish_test();
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial forever #50 clk = ~clk;
    initial forever #32 lnk = ~lnk;
    // Released wires show the inverse of their last level
    always @(posedge clk) begin
        c_last <= clk_w;
        d_last <= dat_w;
    end
    // Watchdog
    initial begin
        #3000000;
        errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        acc(0, VSR_RS_ENABLES, 8'h00);
        chk(r, 8'h00);
        b = 8'($random(seed));
        acc(1, VSR_RS_ENABLES, b | 8'h80);
        acc(0, VSR_RS_ENABLES, 8'h00);
        chk(r, b & 8'h7f);
        acc(1, VSR_RS_ENABLES, b & 8'h7f);
        acc(0, VSR_RS_ENABLES, 8'h00);
        chk(r, 8'h00);
        // Timer flags, request line and summary bit
        acc(1, VSR_RS_ENABLES, 8'he0);
        t1 <= 1'b1;
        t2 <= 1'b1;
        @(posedge clk);
        t1 <= 1'b0;
        t2 <= 1'b0;
        pa <= 1'b0;
        repeat (6) @(posedge clk);
        acc(0, VSR_RS_FLAGS, 8'h00);
        chk(r & 8'he7, 8'he3);
        chk({7'h0, irq_oe_n}, 8'h00);
        acc(1, VSR_RS_FLAGS, 8'ha0);
        acc(1, VSR_RS_PORT_A, b);
        acc(0, VSR_RS_FLAGS, 8'h00);
        chk(r & 8'he7, 8'hc0);
        acc(0, VSR_RS_T1_LO, 8'h00);
        acc(0, VSR_RS_FLAGS, 8'h00);
        chk(r & 8'he7, 8'h00);
        chk({7'h0, irq_oe_n}, 8'h01);
        // Timer-paced and system-rate output, manual idle level on the data line
        peripheral_ctrl_reg <= {2'b11, b[0], 5'h00};
        for (int m = 5; m <= 6; m++) begin
            lat <= 8'($random(seed)) & 8'h03;
            acc(1, VSR_RS_AUX, 8'(m << 2));
            acc(1, VSR_RS_SHIFTER, b);
            if (m == 5) acc(1, VSR_RS_SHIFTER, b);
            wait_flag();
            chk(i_dev.rx_q, b);
            if (m == 5) chk({7'h0, dat_w}, {7'h0, b[0]});
            acc(0, VSR_RS_SHIFTER, 8'h00);
            chk(r, b);
        end
        // Free-running output repeats with no flag
        acc(1, VSR_RS_AUX, 8'h10);
        acc(1, VSR_RS_SHIFTER, b);
        wait_bits(9);
        b = i_dev.rx_q;
        wait_bits(8);
        chk(i_dev.rx_q, b);
        acc(0, VSR_RS_FLAGS, 8'h00);
        chk(r & 8'h04, 8'h00);
        // Timer-paced input
        b = 8'($random(seed));
        din <= 1'b1;
        lat <= 8'h07;
        acc(1, VSR_RS_AUX, 8'h04);
        wait_flag();
        #800;
        i_dev.load(b);
        acc(1, VSR_RS_SHIFTER, 8'h00);
        wait_flag();
        acc(0, VSR_RS_SHIFTER, 8'h00);
        chk(r, b);
        // External clock in
        ext <= 1'b1;
        acc(1, VSR_RS_AUX, 8'h0c);
        i_dev.load(~b);
        acc(0, VSR_RS_SHIFTER, 8'h00);
        i_dev.frame();
        repeat (8) @(posedge clk);
        acc(0, VSR_RS_FLAGS, 8'h00);
        chk(r & 8'h04, 8'h04);
        acc(0, VSR_RS_SHIFTER, 8'h00);
        chk(r, ~b);
        // External clock out
        din <= 1'b0;
        acc(1, VSR_RS_AUX, 8'h1c);
        acc(1, VSR_RS_SHIFTER, b);
        i_dev.frame();
        repeat (8) @(posedge clk);
        chk(i_dev.rx_q, b);
        acc(0, VSR_RS_FLAGS, 8'h00);
        chk(r & 8'h04, 8'h04);
        // System-rate input: clock stops high after 8 pulses
        acc(1, VSR_RS_AUX, 8'h08);
        acc(1, VSR_RS_SHIFTER, 8'h00);
        repeat (20) @(posedge clk);
        chk({7'h0, c_o}, 8'h01);
        acc(0, VSR_RS_FLAGS, 8'h00);
        chk(r & 8'h04, 8'h04);
        // Disabled shifter still reads and writes, flag held low
        acc(1, VSR_RS_AUX, 8'h00);
        acc(0, VSR_RS_FLAGS, 8'h00);
        chk(r & 8'h04, 8'h00);
        acc(1, VSR_RS_SHIFTER, ~b);
        acc(0, VSR_RS_SHIFTER, 8'h00);
        chk(r, ~b);
        finish_test();
    end
endmodule
`default_nettype wire
